// ---- src/spi_port_pkg.sv ----
// Constants and types for the serial peripheral port.
// Assumes a single 20 MHz core clock and plain strobe ports for register access.
// How it works
// - Bytes shift MSB first; data in and out follow the master's clock.
// - Soft select mode ignores the select pin; internal select follows the level bit.
// - Slave with capture phase zero: select pulses per byte; writes while low collide.
// - Master drives the serial clock at the chosen rate, polarity and phase.
// - As master, master and enable bits stay set only while internal select is high.
// - Data write loads the shifter; it shifts out on the active data pin.
// - Byte end sets transfer done; interrupt if enabled and CPU mask clear.
// - Done clears after status access then data read, or read/write as slave.
// - Data writes are dropped while done is set until status is read.
// - Slave shifts on the incoming clock; the master always starts transfers.
// - Both ends use the same polarity and phase combination.
// - Select low as master sets mode fault and clears enable and master.
// - Mode fault clears by status read then control write.
// - Mode fault blocks setting enable and master outside its clear sequence.
// - Byte ending while done is set raises overrun; first byte kept; status read clears.
// - Data write during a transfer is ignored and sets write collision, no interrupt.
// - Idle level zero gives low idle clock, one gives high.
// - Phase zero captures on the first transition, phase one on the second.
// - Rate bits give divide by 2,4,8,16,32,64; no effect as slave.
// - Reset clears the port enable bit.
package spi_port_pkg;
    localparam int         BYTE_W     = 8;
    localparam int         FIFO_DEPTH = 8;
    localparam logic [3:0] EDGE_LAST  = 4'hf;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [1:0] CSR_RESET  = 2'h0;
    localparam logic [2:0] RATE_DIV2  = 3'h4;
    localparam logic [2:0] RATE_DIV4  = 3'h0;
    localparam logic [2:0] RATE_DIV8  = 3'h1;
    localparam logic [2:0] RATE_DIV16 = 3'h6;
    localparam logic [2:0] RATE_DIV32 = 3'h2;
    localparam logic [2:0] RATE_DIV64 = 3'h3;
    localparam logic [5:0] HALF_DIV2  = 6'h01;
    localparam logic [5:0] HALF_DIV4  = 6'h02;
    localparam logic [5:0] HALF_DIV8  = 6'h04;
    localparam logic [5:0] HALF_DIV16 = 6'h08;
    localparam logic [5:0] HALF_DIV32 = 6'h10;
    localparam logic [5:0] HALF_DIV64 = 6'h20;

    typedef struct packed {
        logic irq_en;
        logic port_en;
        logic rate_hi;
        logic master;
        logic idle_level;
        logic capture_phase;
        logic rate_mid;
        logic rate_lo;
    } ctrl_t;

    typedef struct packed {
        logic soft_select_mode;
        logic soft_select_level;
    } csr_ctrl_t;

    typedef struct packed {
        logic transfer_done;
        logic write_collision;
        logic overrun;
        logic mode_fault;
    } status_t;

    // Core cycles per serial clock half period
    function automatic logic [5:0] half_period(input logic [2:0] code);
        case (code)
            RATE_DIV2:  return HALF_DIV2;
            RATE_DIV8:  return HALF_DIV8;
            RATE_DIV16: return HALF_DIV16;
            RATE_DIV32: return HALF_DIV32;
            RATE_DIV64: return HALF_DIV64;
            default:    return HALF_DIV4;
        endcase
    endfunction : half_period
endpackage : spi_port_pkg

// ---- src/serial_peripheral_port.sv ----
// Serial peripheral port: master/slave byte shifter, flags and receive FIFO.
// Assumes register accesses arrive as one-cycle strobes on the core clock.
`timescale 1ns/1ns

// ----------------------------------------
// Receive FIFO
// ----------------------------------------
module sync_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input  wire logic             core_clk_i,
    input  wire logic             rst_i,
    // Fill side
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    // Drain side
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic [WIDTH-1:0]      out_data_o
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [AW:0]      count;
    logic             push;
    logic             pop;

    assign in_ready_o  = count != (AW+1)'(DEPTH);
    assign out_valid_o = count != '0;
    assign out_data_o  = mem[rd_ptr];
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;

    always_ff @(posedge core_clk_i) begin
        if (push) begin
            mem[wr_ptr] <= in_data_i;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
            end
            count <= count + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule : sync_fifo

// ----------------------------------------
// Port top
// ----------------------------------------
module serial_peripheral_port #(
    parameter int FIFO_D = spi_port_pkg::FIFO_DEPTH
) (
    // Clock and reset
    input  wire logic                     core_clk_i,
    input  wire logic                     rst_i,
    // Register strobes
    input  wire logic                     ctrl_wr_i,
    input  wire spi_port_pkg::ctrl_t      ctrl_wdata_i,
    input  wire logic                     csr_wr_i,
    input  wire spi_port_pkg::csr_ctrl_t  csr_wdata_i,
    input  wire logic                     csr_rd_i,
    input  wire logic                     data_wr_i,
    input  wire logic [7:0]               data_wdata_i,
    input  wire logic                     data_rd_i,
    input  wire logic                     cpu_irq_mask_i,
    // Register views
    output spi_port_pkg::ctrl_t           ctrl_o,
    output spi_port_pkg::csr_ctrl_t       csr_o,
    output spi_port_pkg::status_t         status_o,
    output logic [7:0]                    data_rdata_o,
    output logic                          irq_o,
    // Pins
    input  wire logic                     sck_i,
    output logic                          sck_o,
    output logic                          sck_oe_n_o,
    input  wire logic                     mosi_i,
    output logic                          mosi_o,
    output logic                          mosi_oe_n_o,
    input  wire logic                     miso_i,
    output logic                          miso_o,
    output logic                          miso_oe_n_o,
    input  wire logic                     ss_n_i
);
    import spi_port_pkg::*;

    ctrl_t      ctrl;
    ctrl_t      next_ctrl;
    csr_ctrl_t  csr;
    status_t    st;
    logic [3:0] pin_m;
    logic [3:0] pin_s;
    logic       sck_d;
    logic       ss_int;
    logic       master_on;
    logic       slave_on;
    logic       running;
    logic [5:0] div_cnt;
    logic [5:0] half;
    logic       tick;
    logic       sck_q;
    logic [3:0] ecnt;
    logic       edge_ev;
    logic       capture;
    logic       last;
    logic       serial_in;
    logic       cap_bit;
    logic [7:0] shift;
    logic [7:0] next_shift;
    logic       busy;
    logic       wr_blocked;
    logic       load;
    logic       fault;
    logic       lost;
    logic       done_seen;
    logic       done_rd_seen;
    logic       write_collision_flag_seen;
    logic       mode_fault_flag_seen;
    logic [7:0] rx_buf;
    logic [7:0] rx_byte;
    logic       f_in_ready;
    logic       f_out_valid;
    logic [7:0] f_out_data;
    logic       pop;

    // ----------------------------------------
    // Pin synchronisers {sck, mosi, miso, ss_n}
    // ----------------------------------------
    always_ff @(posedge core_clk_i) begin
        pin_m <= {sck_i, mosi_i, miso_i, ss_n_i};
        pin_s <= pin_m;
        sck_d <= pin_s[3];
    end

    assign ss_int    = csr.soft_select_mode ? csr.soft_select_level : pin_s[0];
    assign master_on = ctrl.port_en && ctrl.master;
    assign slave_on  = ctrl.port_en && !ctrl.master && !ss_int;
    assign fault     = ctrl.master && !ss_int;

    // ----------------------------------------
    // Control registers
    // ----------------------------------------
    always_comb begin
        next_ctrl = ctrl;
        if (ctrl_wr_i) begin
            next_ctrl = ctrl_wdata_i;
            // Outside the clearing sequence a fault keeps the port off
            if (st.mode_fault && !mode_fault_flag_seen) begin
                next_ctrl.port_en = 1'b0;
                next_ctrl.master  = 1'b0;
            end
        end
        if (fault) begin
            next_ctrl.port_en = 1'b0;
            next_ctrl.master  = 1'b0;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            ctrl <= ctrl_t'(CTRL_RESET);
            csr  <= csr_ctrl_t'(CSR_RESET);
        end else begin
            ctrl <= next_ctrl;
            if (csr_wr_i) begin
                csr <= csr_wdata_i;
            end
        end
    end

    // ----------------------------------------
    // Master clock generator
    // ----------------------------------------
    assign half = half_period({ctrl.rate_hi, ctrl.rate_mid, ctrl.rate_lo});
    assign tick = running && div_cnt == half - 6'h01;

    always_ff @(posedge core_clk_i) begin
        if (rst_i || !running || tick) begin
            div_cnt <= '0;
        end else begin
            div_cnt <= div_cnt + 6'h01;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            running <= 1'b0;
        end else if (!master_on) begin
            running <= 1'b0;
        end else if (load) begin
            running <= 1'b1;
        end else if (last) begin
            running <= 1'b0;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i || !running) begin
            sck_q <= rst_i ? 1'b0 : ctrl.idle_level;
        end else if (tick) begin
            sck_q <= !sck_q;
        end
    end

    // ----------------------------------------
    // Shift engine, shared by master and slave
    // ----------------------------------------
    // Slave edges come from the synchronised pin, so the slave tops out well below
    // the core rate; the faster rates only work as master.
    assign edge_ev   = master_on ? tick : (slave_on && (pin_s[3] ^ sck_d));
    assign capture   = edge_ev && (ecnt[0] == ctrl.capture_phase);
    assign last      = edge_ev && ecnt == EDGE_LAST;
    assign serial_in = master_on ? pin_s[1] : pin_s[2];
    assign busy      = master_on ? running
                     : (slave_on && (!ctrl.capture_phase || ecnt != '0));
    assign wr_blocked = st.transfer_done && !done_rd_seen;
    assign load      = data_wr_i && ctrl.port_en && !wr_blocked && !busy;

    always_comb begin
        next_shift = shift;
        if (load) begin
            next_shift = data_wdata_i;
        end else if (edge_ev && !capture && ecnt != '0) begin
            next_shift = {shift[BYTE_W-2:0], cap_bit};
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            shift   <= '0;
            cap_bit <= 1'b0;
        end else begin
            shift <= next_shift;
            if (capture) begin
                cap_bit <= serial_in;
            end
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i || !ctrl.port_en || (master_on ? !running : ss_int)) begin
            ecnt <= '0;
        end else if (edge_ev) begin
            ecnt <= ecnt + 4'h1;
        end
    end

    // ----------------------------------------
    // Receive path
    // ----------------------------------------
    // Final capture edge leaves the shifter alone, so the data pin holds while sampled
    assign rx_byte = {shift[BYTE_W-2:0], capture ? serial_in : cap_bit};
    assign lost = last && (st.transfer_done || !f_in_ready);
    assign pop  = f_out_valid && !st.transfer_done;

    sync_fifo #(
        .WIDTH (BYTE_W),
        .DEPTH (FIFO_D)
    ) rx_fifo (
        .core_clk_i  (core_clk_i),
        .rst_i       (rst_i),
        .in_valid_i  (last && !st.transfer_done),
        .in_ready_o  (f_in_ready),
        .in_data_i   (rx_byte),
        .out_valid_o (f_out_valid),
        .out_ready_i (!st.transfer_done),
        .out_data_o  (f_out_data)
    );

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            rx_buf <= '0;
        end else if (pop) begin
            rx_buf <= f_out_data;
        end
    end

    // ----------------------------------------
    // Status flags: a set always wins over a clear
    // ----------------------------------------
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            st           <= '0;
            done_seen    <= 1'b0;
            done_rd_seen <= 1'b0;
            write_collision_flag_seen    <= 1'b0;
            mode_fault_flag_seen    <= 1'b0;
        end else begin
            if (st.transfer_done && (csr_rd_i || csr_wr_i)) begin
                done_seen <= 1'b1;
            end
            if (st.transfer_done && csr_rd_i) begin
                done_rd_seen <= 1'b1;
            end
            if (pop) begin
                st.transfer_done <= 1'b1;
            end else if (done_seen && (data_rd_i || (data_wr_i && !ctrl.master))) begin
                st.transfer_done <= 1'b0;
                done_seen        <= 1'b0;
                done_rd_seen     <= 1'b0;
            end
            if (st.write_collision && (csr_rd_i || csr_wr_i)) begin
                write_collision_flag_seen <= 1'b1;
            end
            if (data_wr_i && ctrl.port_en && busy) begin
                st.write_collision <= 1'b1;
            end else if (write_collision_flag_seen && (data_rd_i || data_wr_i)) begin
                st.write_collision <= 1'b0;
                write_collision_flag_seen          <= 1'b0;
            end
            if (lost) begin
                st.overrun <= 1'b1;
            end else if (csr_rd_i) begin
                st.overrun <= 1'b0;
            end
            if (st.mode_fault && csr_rd_i) begin
                mode_fault_flag_seen <= 1'b1;
            end
            if (fault) begin
                st.mode_fault <= 1'b1;
            end else if (mode_fault_flag_seen && ctrl_wr_i) begin
                st.mode_fault <= 1'b0;
                mode_fault_flag_seen     <= 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= ctrl.irq_en && !cpu_irq_mask_i
                  && (st.transfer_done || st.overrun || st.mode_fault);
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign ctrl_o       = ctrl;
    assign csr_o        = csr;
    assign status_o     = st;
    assign data_rdata_o = rx_buf;
    assign sck_o        = sck_q;
    assign sck_oe_n_o   = !master_on;
    assign mosi_o       = shift[BYTE_W-1];
    assign mosi_oe_n_o  = !master_on;
    assign miso_o       = shift[BYTE_W-1];
    assign miso_oe_n_o  = !slave_on;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (rst_i);

    a_fault_drops_master: assert property (fault |=> !ctrl.port_en && !ctrl.master
        && st.mode_fault) else $error("mode fault did not disable port");
    a_fault_only_master: assert property ($rose(st.mode_fault) |-> $past(ctrl.master))
        else $error("mode fault raised as slave");
    a_soft_select_low: assert property (csr.soft_select_mode && !csr.soft_select_level
        && ctrl.master |=> !ctrl.master) else $error("soft select low kept master");
    a_done_irq_out: assert property (st.transfer_done && ctrl.irq_en && !cpu_irq_mask_i
        |=> irq_o) else $error("no interrupt for transfer done");
    a_done_after_byte: assert property (last && !st.transfer_done |-> ##2 st.transfer_done)
        else $error("done not set after byte");
    a_blocked_write: assert property (data_wr_i && wr_blocked && !running
        |=> !running) else $error("blocked write started transfer");
    a_collision_set: assert property (data_wr_i && ctrl.port_en && busy
        |=> st.write_collision) else $error("collision flag missed");
    a_overrun_set: assert property (lost |=> st.overrun)
        else $error("overrun flag missed");
    a_sck_idle_level: assert property (!running |=> !running || sck_o == $past(ctrl.idle_level))
        else $error("clock not at idle level");
    a_fast_byte_len: assert property ($rose(running) && half == HALF_DIV2
        |-> running[*8] ##8 running ##1 !running) else $error("byte length wrong at fastest rate");
    a_msb_first_out: assert property (load && master_on |=> mosi_o == $past(data_wdata_i[7]))
        else $error("msb not presented first");

    c_master_byte: cover property (master_on && last);
    c_mode_fault: cover property ($rose(st.mode_fault));
    c_overrun: cover property ($rose(st.overrun));
endmodule : serial_peripheral_port

// ---- bench/far_slave.sv ----
// Far-end serial slave model used against the port in master operation.
// Assumes the bench resolves shared pins and pulses select once per byte.
`timescale 1ns/1ns
// ----------------------------------------
// Far slave
// ----------------------------------------
module far_slave (
    // Pins
    input  wire logic       sck_i,
    input  wire logic       mosi_i,
    input  wire logic       sel_n_i,
    output logic            miso_o,
    // Setup and result
    input  wire logic       clock_capture_phase_i,
    input  wire logic [7:0] tx_i,
    output logic [7:0]      rx_o
);
    logic [7:0] sh;
    int         n;
    initial begin
        miso_o = 1'b0;
        rx_o   = 8'h00;
    end
    // Released line shows the inverse so a stale bit never passes
    always @(posedge sel_n_i) miso_o = ~miso_o;
    always @(negedge sel_n_i) begin
        n  = 0;
        sh = tx_i;
        if (!clock_capture_phase_i) begin
            miso_o = sh[7];
            sh     = sh << 1;
        end
    end
    always @(sck_i) begin
        if (!sel_n_i) begin
            n = n + 1;
            if (n[0] ^ clock_capture_phase_i) begin
                rx_o = {rx_o[6:0], mosi_i};
            end else begin
                miso_o = sh[7];
                sh     = sh << 1;
            end
        end
    end
endmodule : far_slave

// ---- bench/tb_serial_peripheral_port.sv ----
// Self-checking bench for the serial peripheral port.
// Assumes the package, the design and the far slave model compile first.
`timescale 1ns/1ns
module tb_serial_peripheral_port;
    import spi_port_pkg::*;
    // ----------------------------------------
    // Signals
    // ----------------------------------------
    localparam int CTL_WR = 0, CSR_WR = 1, CSR_RD = 2, DAT_WR = 3, DAT_RD = 4;
    logic       core_clk_i = 1'b0, rst_i = 1'b1, cpu_irq_mask_i = 1'b0, ss_n_i = 1'b1;
    logic       ctrl_wr_i = 1'b0, csr_wr_i = 1'b0, csr_rd_i = 1'b0;
    logic       data_wr_i = 1'b0, data_rd_i = 1'b0;
    logic       tb_sck = 1'b0, tb_mosi = 1'b0, far_sel_n = 1'b1, far_clock_capture_phase = 1'b0;
    ctrl_t      ctrl_wdata_i = '0, ctrl_o, c;
    csr_ctrl_t  csr_wdata_i = '0, csr_o;
    status_t    status_o;
    logic [7:0] data_wdata_i = 8'h00, data_rdata_o, far_tx = 8'h00, far_rx, srx;
    logic       irq_o, sck_o, sck_oe_n_o, mosi_o, mosi_oe_n_o, miso_o, miso_oe_n_o;
    logic       far_miso, sck_w, mosi_w, miso_w;
    logic [2:0] codes [6];
    int         bad_count = 0, total_checks = 0, edges = 0, k = 0;
    assign sck_w  = sck_oe_n_o ? tb_sck : sck_o;
    assign mosi_w = mosi_oe_n_o ? tb_mosi : mosi_o; // Separate data wires, full duplex
    assign miso_w = miso_oe_n_o ? far_miso : miso_o;
    always #25 core_clk_i = ~core_clk_i;
    always @(sck_o) edges++;
    serial_peripheral_port u_serial_peripheral_port (
        .core_clk_i(core_clk_i), .rst_i(rst_i), .ctrl_wr_i(ctrl_wr_i),
        .ctrl_wdata_i(ctrl_wdata_i), .csr_wr_i(csr_wr_i), .csr_wdata_i(csr_wdata_i),
        .csr_rd_i(csr_rd_i), .data_wr_i(data_wr_i), .data_wdata_i(data_wdata_i),
        .data_rd_i(data_rd_i), .cpu_irq_mask_i(cpu_irq_mask_i), .ctrl_o(ctrl_o),
        .csr_o(csr_o), .status_o(status_o), .data_rdata_o(data_rdata_o), .irq_o(irq_o),
        .sck_i(sck_w), .sck_o(sck_o), .sck_oe_n_o(sck_oe_n_o), .mosi_i(mosi_w),
        .mosi_o(mosi_o), .mosi_oe_n_o(mosi_oe_n_o), .miso_i(miso_w), .miso_o(miso_o),
        .miso_oe_n_o(miso_oe_n_o), .ss_n_i(ss_n_i));
    far_slave u_far_slave (.sck_i(sck_w), .mosi_i(mosi_w), .sel_n_i(far_sel_n),
        .miso_o(far_miso), .clock_capture_phase_i(far_clock_capture_phase), .tx_i(far_tx), .rx_o(far_rx));
    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic strobe(input int s, input logic [7:0] v);
        @(negedge core_clk_i);
        ctrl_wdata_i = v;
        csr_wdata_i  = v[1:0];
        data_wdata_i = v;
        {ctrl_wr_i, csr_wr_i, csr_rd_i, data_wr_i, data_rd_i} = 5'h10 >> s;
        @(negedge core_clk_i);
        {ctrl_wr_i, csr_wr_i, csr_rd_i, data_wr_i, data_rd_i} = 5'h00;
    endtask : strobe
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic wait_done(input int lim);
        k = 0;
        while (status_o.transfer_done !== 1'b1 && k < lim) begin
            @(negedge core_clk_i);
            k++;
        end
    endtask : wait_done
    task automatic finish_test();
        $display("Checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : finish_test
    // Whole run needs about 1800 cycles; allow generous slack
    initial begin
        #(20000 * 50);
        bad_count++;
        finish_test();
    end
    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial begin
        codes = '{RATE_DIV2, RATE_DIV4, RATE_DIV8, RATE_DIV16, RATE_DIV32, RATE_DIV64};
        repeat (16) @(negedge core_clk_i);
        rst_i = 1'b0;
        chk("ctrl reset", 8'h00, ctrl_o);
        chk("sck oe reset", 8'h01, {7'h0, sck_oe_n_o});
        strobe(CSR_WR, 8'h03);
        chk("csr", 8'h03, {6'h0, csr_o});
        ss_n_i = 1'b0;
        for (int i = 0; i < 6; i++) begin
            c = '0;
            {c.irq_en, c.port_en, c.master} = 3'h7;
            {c.idle_level, c.capture_phase} = {i[0], i[1]};
            {c.rate_hi, c.rate_mid, c.rate_lo} = codes[i];
            far_clock_capture_phase = c.capture_phase;
            far_tx = 8'hc3 ^ 8'(i);
            cpu_irq_mask_i = (i == 2);
            strobe(CTL_WR, c & 8'hbf);
            strobe(CTL_WR, c);
            chk("sck idle", {7'h0, c.idle_level}, {7'h0, sck_o});
            chk("pin oe", 8'h01, {6'h0, mosi_oe_n_o, miso_oe_n_o});
            far_sel_n = 1'b0;
            edges = 0;
            strobe(DAT_WR, 8'ha5 ^ 8'(i));
            strobe(DAT_WR, 8'hff);
            chk("collision", 8'h01, {7'h0, status_o.write_collision});
            wait_done(3000);
            chk("byte time", 8'h01, {7'h0, k >= (16 << i) - 1 && k <= (16 << i) + 1});
            chk("sck edges", 8'd16, 8'(edges));
            chk("far rx", 8'ha5 ^ 8'(i), far_rx);
            if (i >= 2) chk("master rx", far_tx, data_rdata_o);
            @(negedge core_clk_i);
            chk("irq", {7'h0, i != 2}, {7'h0, irq_o});
            chk("sck back idle", {7'h0, c.idle_level}, {7'h0, sck_o});
            far_sel_n = 1'b1;
            if (i == 0) begin
                strobe(DAT_WR, 8'h00);
                repeat (40) @(negedge core_clk_i);
                chk("dropped write", 8'd16, 8'(edges));
            end
            if (i == 5) begin
                strobe(CSR_RD, 8'h00);
                far_tx = 8'h5e;
                far_sel_n = 1'b0;
                strobe(DAT_WR, 8'h77);
                repeat (16 * 32 + 8) @(negedge core_clk_i);
                chk("overrun", 8'h01, {7'h0, status_o.overrun});
                chk("kept byte", 8'hc3 ^ 8'h05, data_rdata_o);
                far_sel_n = 1'b1;
                strobe(CSR_RD, 8'h00);
                chk("overrun clear", 8'h00, {7'h0, status_o.overrun});
            end
            strobe(CSR_RD, 8'h00);
            strobe(DAT_RD, 8'h00);
            chk("done clear", 8'h00, {7'h0, status_o.transfer_done});
            chk("collision clear", 8'h00, {7'h0, status_o.write_collision});
        end
        chk("soft select", 8'h00, {7'h0, status_o.mode_fault});
        strobe(CSR_WR, 8'h00);
        repeat (4) @(negedge core_clk_i);
        chk("fault", 8'h01, {7'h0, status_o.mode_fault});
        chk("fault ctrl", 8'h00, {6'h0, ctrl_o.port_en, ctrl_o.master});
        chk("fault irq", 8'h01, {7'h0, irq_o});
        ss_n_i = 1'b1;
        repeat (4) @(negedge core_clk_i);
        strobe(CTL_WR, 8'hd0);
        chk("fault refuse", 8'h00, {7'h0, ctrl_o.port_en});
        strobe(CSR_RD, 8'h00);
        strobe(CTL_WR, 8'hd0);
        chk("fault clear", 8'h00, {7'h0, status_o.mode_fault});
        chk("ctrl kept", 8'h03, {6'h0, ctrl_o.port_en, ctrl_o.master});
        // Slave with phase one: select held low by soft select
        strobe(CTL_WR, 8'h04);
        strobe(CSR_WR, 8'h02);
        strobe(CTL_WR, 8'h44);
        strobe(DAT_WR, 8'h96);
        chk("slave miso oe", 8'h00, {7'h0, miso_oe_n_o});
        for (int b = 7; b >= 0; b--) begin
            tb_sck = 1'b1;
            tb_mosi = b[0] ? 1'b0 : 1'b1;
            repeat (4) @(negedge core_clk_i);
            srx = {srx[6:0], miso_w};
            tb_sck = 1'b0;
            repeat (4) @(negedge core_clk_i);
        end
        wait_done(20);
        chk("slave tx", 8'h96, srx);
        chk("slave rx", 8'h55, data_rdata_o);
        chk("slave no fault", 8'h00, {7'h0, status_o.mode_fault});
        strobe(CSR_RD, 8'h00);
        strobe(DAT_WR, 8'h00);
        chk("slave done clear", 8'h00, {7'h0, status_o.transfer_done});
        finish_test();
    end
endmodule : tb_serial_peripheral_port
